// ### verilog/ovt_regs.sv
// output-voltage target command registers with clamping and sequencing
//
// Operation
// RULE_01 - format byte reads relative flag 1 and linear mode 00; not writable
// RULE_02 - format exponent reads 10111b, minus nine, 1.953mV per count
// RULE_03 - any write to the format byte is invalid data, flagged and alerted
// RULE_04 - target word keeps bits 12:0; bits 15:13 ignore writes, read zero
// RULE_05 - goal is target plus offset plus margin terms from operation bits 5 and 4
// RULE_06 - writes during soft-start are kept; ramp to boot, then to latest target
// RULE_07 - writes during soft-stop acknowledged, no transition; reload boot at its end
// RULE_08 - after soft-start a new write retargets immediately at transition rate
// RULE_09 - at power-up the target loads boot setting divided by loop ratio
// RULE_10 - disabling the rail rewrites the target with the boot voltage
// RULE_11 - reset-selected address pin asserted returns target to boot voltage
// RULE_12 - written target plus offset beyond ceiling or floor is replaced by that limit
// RULE_13 - ceiling or floor clamp sets max/min warning and alerts the host
// RULE_14 - target above converter limit but below ceiling gives no warning
// RULE_15 - the offset is added to the target as a fixed signed value
// RULE_16 - offset changes slew at the transition rate
// RULE_17 - offset bits 6:0 writable; bits 15:7 read as sign extension of bit 6
// RULE_18 - usable offset range is +123mV to -125mV
// RULE_19 - target plus offset past converter limit clamps there and warns
// RULE_20 - offset write outside range is invalid data, flagged and alerted
// RULE_21 - max/min warning also sets the vout summary in the status word high byte
// RULE_22 - sequencer states come in; target and slew request go to the reference
`timescale 1ns/1ps
module ovt_regs (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        ce_in,
  // command port from the bus interface
  input  wire logic        cmd_valid_in,
  input  wire logic        cmd_write_in,
  input  wire logic [7:0]  cmd_code_in,
  input  wire logic [15:0] cmd_wdata_in,
  output logic      [15:0] cmd_rdata_out,
  output logic             cmd_ack_out,
  // limits and factors held by neighbouring registers
  input  wire logic [11:0] vout_max_in,
  input  wire logic [15:0] vout_min_in,
  input  wire logic [10:0] margin_high_in,
  input  wire logic [10:0] margin_low_in,
  input  wire logic [7:0]  operation_in,
  input  wire logic [3:0]  scale_loop_in,
  input  wire logic [12:0] boot_voltage_setting_in,
  input  wire logic        reset_pin_select_in,
  input  wire logic        address_or_reset_pin_n_in,
  // power sequencer
  input  wire logic        soft_start_active_in,
  input  wire logic        soft_stop_active_in,
  input  wire logic        rail_disabled_in,
  input  wire logic        soft_start_tick_in,
  input  wire logic        transition_tick_in,
  // status
  input  wire logic        status_clear_in,
  output logic [7:0]       status_vout_out,
  output logic [15:0]      status_word_out,
  output logic             cml_invalid_data_out,
  output logic             alert_out,
  // reference generator
  output logic [15:0]      target_out,
  output logic             slew_request_out
);

  import ovt_pkg::*;
  default clocking cb_core @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  // ***************************************************************
  // pin synchroniser and edge tracking
  // ***************************************************************
  logic rst_pin_s1_q;
  logic rst_pin_s2_q;
  logic soft_stop_prev_q;
  logic boot_pending_q;

  // the pin is asynchronous to the core clock; only s2 is read by logic
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      rst_pin_s1_q <= 1'b1;
      rst_pin_s2_q <= 1'b1;
    end else if (ce_in) begin
      rst_pin_s1_q <= address_or_reset_pin_n_in;
      rst_pin_s2_q <= rst_pin_s1_q;
    end
  end

  // previous soft-stop level, and a one-shot boot load after reset release
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      soft_stop_prev_q <= 1'b0;
      boot_pending_q   <= 1'b1;
    end else if (ce_in) begin
      soft_stop_prev_q <= soft_stop_active_in;
      boot_pending_q   <= 1'b0;
    end
  end

  // ***************************************************************
  // boot value and converter ceiling
  // ***************************************************************
  logic [1:0]  scale_shift;
  logic [12:0] boot_value;
  logic [15:0] hw_max;

  // loop mantissa 8 is unity; smaller mantissas divide the feedback, so scale up
  always_comb begin
    unique case (scale_loop_in)
      4'h8:    scale_shift = 2'd0;
      4'h4:    scale_shift = 2'd1;
      4'h2:    scale_shift = 2'd2;
      4'h1:    scale_shift = 2'd3;
      default: scale_shift = 2'd0;  // unsupported mantissa treated as unity
    endcase
  end

  assign boot_value = boot_voltage_setting_in << scale_shift;                     // RULE_09
  assign hw_max     = 16'(OVT_DAC_LIMIT_CNT) << scale_shift;                      // RULE_14

  // ***************************************************************
  // request decode
  // ***************************************************************
  logic        wr_fmt;
  logic        wr_cmd;
  logic        wr_trim;
  logic        trim_ok;
  logic        soft_stop_done;
  logic        force_boot;
  logic signed [19:0] trim_ext;
  logic signed [19:0] wr_sum;
  logic        wr_above;
  logic        wr_below;

  assign wr_fmt  = ce_in && cmd_valid_in && cmd_write_in && (cmd_code_in == OVT_CODE_FORMAT);
  assign wr_cmd  = ce_in && cmd_valid_in && cmd_write_in && (cmd_code_in == OVT_CODE_TARGET);
  assign wr_trim = ce_in && cmd_valid_in && cmd_write_in && (cmd_code_in == OVT_CODE_OFFSET);

  // upper nine bits must all copy bit 6, which bounds the offset to -64..63 counts
  assign trim_ok = cmd_wdata_in[15:OVT_TRIM_SIGN] == {10{cmd_wdata_in[OVT_TRIM_SIGN]}};  // RULE_18

  assign soft_stop_done = soft_stop_prev_q && !soft_stop_active_in;                // RULE_07
  assign force_boot     = boot_pending_q || rail_disabled_in || soft_stop_done ||  // RULE_10
                          (reset_pin_select_in && !rst_pin_s2_q);                  // RULE_11

  // ***************************************************************
  // target and offset registers
  // ***************************************************************
  logic [12:0] cmd_q;
  logic [6:0]  trim_q;

  assign trim_ext = 20'(signed'(trim_q));                                         // RULE_15
  assign wr_sum   = signed'({7'h00, cmd_wdata_in[12:0]}) + trim_ext;
  assign wr_above = wr_sum > signed'({8'h00, vout_max_in});
  assign wr_below = wr_sum < signed'({4'h0, vout_min_in});

  // boot reload wins over a host write in the same cycle
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      cmd_q <= OVT_CMD_RESET;
    end else if (ce_in) begin
      if (force_boot) begin
        cmd_q <= boot_value;                                                      // RULE_09
      end else if (wr_cmd) begin
        if (wr_above) begin
          cmd_q <= {1'b0, vout_max_in};                                           // RULE_12
        end else if (wr_below) begin
          cmd_q <= vout_min_in[12:0];                                             // RULE_12
        end else begin
          cmd_q <= cmd_wdata_in[12:0];                                            // RULE_04
        end
      end
    end
  end

  // only the low seven bits are stored; the rest is rebuilt on read
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      trim_q <= OVT_TRIM_RESET;
    end else if (wr_trim && trim_ok) begin
      trim_q <= cmd_wdata_in[OVT_TRIM_W-1:0];                                     // RULE_17
    end
  end

  // ***************************************************************
  // goal computation
  // ***************************************************************
  logic signed [25:0] cmd_s;
  logic signed [25:0] hi_term;
  logic signed [25:0] lo_term;
  logic signed [25:0] raw_goal;
  logic [15:0]        goal;
  logic               goal_over_max;
  logic               goal_over_hw;

  // margin factors are relative, 512 counts meaning a factor of one
  always_comb begin
    cmd_s   = signed'({13'h0000, cmd_q});
    hi_term = ((cmd_s * signed'({15'h0000, margin_high_in})) >>> OVT_EXP_SHIFT) - cmd_s;
    lo_term = cmd_s - ((cmd_s * signed'({15'h0000, margin_low_in})) >>> OVT_EXP_SHIFT);
    raw_goal = cmd_s + 26'(trim_ext);                                             // RULE_05
    if (operation_in[5]) begin
      raw_goal = raw_goal + hi_term;                                              // RULE_05
    end
    if (operation_in[4]) begin
      raw_goal = raw_goal - lo_term;                                              // RULE_05
    end
  end

  assign goal_over_max = raw_goal > signed'({14'h0000, vout_max_in});
  assign goal_over_hw  = raw_goal > signed'({10'h000, hw_max});

  // during soft-start or soft-stop the rail heads for boot; otherwise the latest request
  always_comb begin
    if (soft_start_active_in || soft_stop_active_in) begin
      goal = {3'h0, boot_value};                                                  // RULE_06
    end else if (raw_goal < 26'sd0) begin
      goal = 16'h0000;
    end else if (goal_over_max && ({4'h0, vout_max_in} <= hw_max)) begin
      goal = {4'h0, vout_max_in};
    end else if (goal_over_hw) begin
      goal = hw_max;                                                              // RULE_19
    end else begin
      goal = raw_goal[15:0];                                                      // RULE_08
    end
  end

  // ***************************************************************
  // slew toward the reference
  // ***************************************************************
  // soft-start keeps its own ramp rate; everything else uses the transition rate
  ovt_slew u_slew (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .ce_in      (ce_in),
    .tick_in    (soft_start_active_in ? soft_start_tick_in : transition_tick_in),  // RULE_16
    .goal_in    (goal),
    .level_out  (target_out),
    .busy_out   (slew_request_out)
  );                                                                              // RULE_22

  // ***************************************************************
  // status flags
  // ***************************************************************
  logic warn_q;
  logic ivd_q;
  logic warn_set;
  logic ivd_set;

  // a converter-limit clamp warns only when the offset is nonzero or the goal is also above the ceiling
  assign warn_set = (wr_cmd && !force_boot && (wr_above || wr_below)) ||          // RULE_13
                    (ce_in && !soft_start_active_in && !soft_stop_active_in &&
                     !rail_disabled_in &&
                     (goal_over_max || (goal_over_hw && trim_q != 7'h00)));       // RULE_14
  assign ivd_set  = wr_fmt || (wr_trim && !trim_ok);                              // RULE_20

  // set wins over a clear landing in the same cycle
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      warn_q <= 1'b0;
    end else if (ce_in) begin
      warn_q <= warn_set || (warn_q && !status_clear_in);                         // RULE_19
    end
  end

  // invalid-data flag for the communication status block
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ivd_q <= 1'b0;
    end else if (ce_in) begin
      ivd_q <= ivd_set || (ivd_q && !status_clear_in);                            // RULE_03
    end
  end

  always_comb begin
    status_vout_out = 8'h00;
    status_vout_out[OVT_SV_MAXMIN_POS] = warn_q;
    status_word_out = 16'h0000;
    status_word_out[OVT_SW_VOUT_POS] = warn_q;                                    // RULE_21
    status_word_out[OVT_SW_NOTA_POS] = warn_q;
  end

  assign cml_invalid_data_out = ivd_q;
  assign alert_out            = warn_q || ivd_q;                                  // RULE_13

  // ***************************************************************
  // read path and acknowledge
  // ***************************************************************
  logic [15:0] rdata_q;
  logic        ack_q;

  // writes to the target are acknowledged in every sequencer state
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      rdata_q <= 16'h0000;
      ack_q   <= 1'b0;
    end else if (ce_in) begin
      ack_q <= cmd_valid_in;                                                      // RULE_07
      if (cmd_valid_in && !cmd_write_in) begin
        unique case (cmd_code_in)
          OVT_CODE_FORMAT: rdata_q <= {8'h00, OVT_FMT_VALUE};                     // RULE_01
          OVT_CODE_TARGET: rdata_q <= {3'h0, cmd_q};                              // RULE_04
          OVT_CODE_OFFSET: rdata_q <= {{9{trim_q[OVT_TRIM_SIGN]}}, trim_q};       // RULE_17
          default:         rdata_q <= 16'h0000;
        endcase
      end
    end
  end

  assign cmd_rdata_out = rdata_q;
  assign cmd_ack_out   = ack_q;

  // ***************************************************************
  // assertions
  // ***************************************************************
  property p_fmt_read;
    ce_in && cmd_valid_in && !cmd_write_in && cmd_code_in == OVT_CODE_FORMAT
      |=> cmd_rdata_out == 16'h0097;
  endproperty
  a_fmt_read: assert property (p_fmt_read) else $error("format byte wrong"); // RULE_02

  property p_fmt_write;
    wr_fmt |=> cml_invalid_data_out && alert_out;
  endproperty
  a_fmt_write: assert property (p_fmt_write) else $error("format write not flagged"); // RULE_03

  property p_cmd_upper;
    ce_in && cmd_valid_in && !cmd_write_in && cmd_code_in == OVT_CODE_TARGET
      |=> cmd_rdata_out[15:13] == 3'h0 && cmd_rdata_out[12:0] == $past(cmd_q);
  endproperty
  a_cmd_upper: assert property (p_cmd_upper) else $error("target read wrong"); // RULE_04

  property p_stop_reload;
    ce_in && soft_stop_done |=> cmd_q == $past(boot_value);
  endproperty
  a_stop_reload: assert property (p_stop_reload) else $error("no boot after stop"); // RULE_07

  property p_disable_reload;
    ce_in && rail_disabled_in ##1 ce_in && rail_disabled_in |=> cmd_q == $past(boot_value);
  endproperty
  a_disable_reload: assert property (p_disable_reload) else $error("no boot on disable"); // RULE_10

  property p_clamp_max;
    wr_cmd && !force_boot && wr_above |=> cmd_q == $past(vout_max_in) && status_vout_out[3];
  endproperty
  a_clamp_max: assert property (p_clamp_max) else $error("ceiling clamp missing"); // RULE_12

  property p_trim_bad;
    wr_trim && !trim_ok |=> trim_q == $past(trim_q) && cml_invalid_data_out;
  endproperty
  a_trim_bad: assert property (p_trim_bad) else $error("bad offset accepted"); // RULE_20

  property p_trim_read;
    ce_in && cmd_valid_in && !cmd_write_in && cmd_code_in == OVT_CODE_OFFSET
      |=> cmd_rdata_out[15:7] == {9{cmd_rdata_out[6]}};
  endproperty
  a_trim_read: assert property (p_trim_read) else $error("offset sign extension"); // RULE_17

  property p_summary;
    status_vout_out[3] |-> status_word_out[15];
  endproperty
  a_summary: assert property (p_summary) else $error("summary bit missing"); // RULE_21

  property p_ss_goal;
    soft_start_active_in |-> goal == {3'h0, boot_value};
  endproperty
  a_ss_goal: assert property (p_ss_goal) else $error("soft-start goal not boot"); // RULE_06
endmodule // ovt_regs

// ### verilog/ovt_pkg.sv
// constants shared by the output-voltage target command registers
package ovt_pkg;

  // ***************************************************************
  // command codes
  // ***************************************************************
  localparam logic [7:0] OVT_CODE_FORMAT  = 8'h20;  // output_voltage_format
  localparam logic [7:0] OVT_CODE_TARGET  = 8'h21;  // output_voltage_target
  localparam logic [7:0] OVT_CODE_OFFSET  = 8'h22;  // output_voltage_offset

  // ***************************************************************
  // format byte fields
  // ***************************************************************
  localparam int         OVT_FMT_REL_POS  = 7;      // relative_format_flag
  localparam int         OVT_FMT_MODE_LSB = 5;
  localparam logic       OVT_FMT_REL      = 1'b1;
  localparam logic [1:0] OVT_FMT_MODE     = 2'h0;   // linear encoding
  localparam logic [4:0] OVT_FMT_EXP      = 5'h17;  // exponent -9
  localparam logic [7:0] OVT_FMT_VALUE    = {OVT_FMT_REL, OVT_FMT_MODE, OVT_FMT_EXP};

  // ***************************************************************
  // target and offset layout
  // ***************************************************************
  localparam int         OVT_CMD_W        = 13;     // writable bits 12:0
  localparam int         OVT_TRIM_W       = 7;      // writable bits 6:0
  localparam int         OVT_TRIM_SIGN    = 6;      // trim_sign_extension source
  localparam logic [12:0] OVT_CMD_RESET   = 13'h0000;
  localparam logic [6:0] OVT_TRIM_RESET   = 7'h00;
  localparam int         OVT_TRIM_MAX_CNT = 63;     // +123mV
  localparam int         OVT_TRIM_MIN_CNT = -64;    // -125mV

  // ***************************************************************
  // scaling
  // ***************************************************************
  localparam int         OVT_EXP_SHIFT    = 9;      // relative factor lsb 1/512
  localparam int         OVT_LSB_UV       = 1953;   // one count, microvolts
  localparam int         OVT_DAC_LIMIT_UV = 750000; // converter ceiling at unity loop
  localparam int         OVT_DAC_LIMIT_CNT = OVT_DAC_LIMIT_UV / OVT_LSB_UV;
  localparam int         OVT_SCALE_REF    = 3;      // loop mantissa 8 is unity

  // ***************************************************************
  // status bit positions
  // ***************************************************************
  localparam int         OVT_SV_MAXMIN_POS = 3;     // status_vout max/min warning
  localparam int         OVT_SW_VOUT_POS   = 15;    // status_word vout summary
  localparam int         OVT_SW_NOTA_POS   = 0;     // none of the above

endpackage

// ### verilog/ovt_slew.sv
// rate-limited follower that walks the reference toward a moving goal
`timescale 1ns/1ps
module ovt_slew (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        ce_in,
  input  wire logic        tick_in,
  input  wire logic [15:0] goal_in,
  output logic      [15:0] level_out,
  output logic             busy_out
);

  // ***************************************************************
  // stepper
  // ***************************************************************
  logic [15:0] level_q;

  // one count per tick; the goal is sampled live, so a new goal retargets at once
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      level_q <= 16'h0000;
    end else if (ce_in && tick_in) begin
      if (level_q < goal_in) begin
        level_q <= level_q + 16'h0001;
      end else if (level_q > goal_in) begin
        level_q <= level_q - 16'h0001;
      end
    end
  end

  assign level_out = level_q;
  assign busy_out  = (level_q != goal_in);  // handshake style, may be combinational

endmodule // ovt_slew

// ### verification/ovt_host.sv
// host model that issues commands on the target register command port
`timescale 1ns/1ps
module ovt_host (
  input  wire logic        clk_in,
  input  wire logic        ack_in,
  input  wire logic [15:0] rdata_in,
  output logic             valid_out,
  output logic             write_out,
  output logic [7:0]       code_out,
  output logic [15:0]      wdata_out
);
  // idle values; the data word is inverted after use so a stale word never looks fresh
  initial begin
    {valid_out, write_out, code_out} = 10'h000;
    wdata_out = 16'ha5a5;
  end
  // one request cycle, then the answer is taken in the cycle after the taking edge
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] r, output logic a);
    @(negedge clk_in);
    {valid_out, write_out, code_out, wdata_out} = {1'b1, w, c, d};
    @(negedge clk_in);
    a = ack_in;
    r = rdata_in;
    {valid_out, wdata_out} = {1'b0, ~d};
  endtask
endmodule // ovt_host

// ### verification/tb.sv
// self-checking bench for the output-voltage target command registers
`timescale 1ns/1ps
module tb;
  import ovt_pkg::*;
  // ***************************************************************
  // signals, named as the design ports
  // ***************************************************************
  logic        clk_in, reset_n_in, ce_in, cmd_valid_in, cmd_write_in, cmd_ack_out, a;
  logic        reset_pin_select_in, address_or_reset_pin_n_in, soft_start_active_in;
  logic        soft_stop_active_in, rail_disabled_in, soft_start_tick_in, transition_tick_in;
  logic        status_clear_in, cml_invalid_data_out, alert_out, slew_request_out;
  logic [7:0]  cmd_code_in, operation_in, status_vout_out;
  logic [15:0] cmd_wdata_in, cmd_rdata_out, vout_min_in, status_word_out, target_out, r;
  logic [11:0] vout_max_in;
  logic [10:0] margin_high_in, margin_low_in;
  logic [3:0]  scale_loop_in;
  logic [12:0] boot_voltage_setting_in;
  int          num_errors, check_count, cycles;
  ovt_regs u_ovt_regs (.*);
  ovt_host u_ovt_host (
    .clk_in    (clk_in),
    .ack_in    (cmd_ack_out),
    .rdata_in  (cmd_rdata_out),
    .valid_out (cmd_valid_in),
    .write_out (cmd_write_in),
    .code_out  (cmd_code_in),
    .wdata_out (cmd_wdata_in)
  );
  always #10 clk_in = ~clk_in;
  // a hang is cut short well past the expected run length
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      num_errors = num_errors + 1;
      tally_and_finish();
    end
  end
  // ***************************************************************
  // shared tasks
  // ***************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    u_ovt_host.xfer(1'b1, c, d, r, a);
    chk({15'h0, a}, 16'h0001, "ack");
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    u_ovt_host.xfer(1'b0, c, 16'h0000, r, a);
    chk(r, e, "read");
  endtask
  task automatic clr();
    status_clear_in = 1'b1;
    cyc(1);
    status_clear_in = 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_format();
    rd(OVT_CODE_FORMAT, 16'h0097);
    wr(OVT_CODE_FORMAT, 16'h0000);
    cyc(1);
    chk({14'h0, cml_invalid_data_out, alert_out}, 16'h0003, "invalid");
    rd(OVT_CODE_FORMAT, 16'h0097);
    clr();
    $display("test format done");
  endtask
  task automatic t_ramp();
    rd(OVT_CODE_TARGET, 16'h012c);
    wr(OVT_CODE_TARGET, 16'h00c8);
    cyc(400);
    chk(target_out, 16'h012c, "soft-start level");
    rd(OVT_CODE_TARGET, 16'h00c8);
    {soft_start_active_in, soft_start_tick_in, transition_tick_in} = 3'b001;
    cyc(150);
    chk(target_out, 16'h00c8, "after soft-start");
    chk({15'h0, slew_request_out}, 16'h0000, "settled");
    // second write lands mid-transition; a detour via 250 would miss 220 here
    wr(OVT_CODE_TARGET, 16'he0fa);
    rd(OVT_CODE_TARGET, 16'h00fa);
    wr(OVT_CODE_TARGET, 16'h00dc);
    cyc(25);
    chk(target_out, 16'h00dc, "retarget");
    $display("test ramp done");
  endtask
  task automatic t_trim();
    wr(OVT_CODE_OFFSET, 16'hffc0);
    rd(OVT_CODE_OFFSET, 16'hffc0);
    wr(OVT_CODE_OFFSET, 16'h0040);
    cyc(1);
    chk({15'h0, cml_invalid_data_out}, 16'h0001, "invalid trim");
    rd(OVT_CODE_OFFSET, 16'hffc0);
    clr();
    wr(OVT_CODE_OFFSET, 16'h003f);
    rd(OVT_CODE_OFFSET, 16'h003f);
    chk({15'h0, slew_request_out}, 16'h0001, "trim slewing");
    cyc(200);
    chk(target_out, 16'h011b, "trimmed level");
    $display("test trim done");
  endtask
  task automatic t_clamp();
    wr(OVT_CODE_OFFSET, 16'h0005);
    wr(OVT_CODE_TARGET, 16'h017e);
    cyc(120);
    chk(target_out, 16'h0180, "hardware limit");
    chk({8'h00, status_vout_out}, 16'h0008, "hw warning");
    wr(OVT_CODE_OFFSET, 16'h0000);
    clr();
    wr(OVT_CODE_TARGET, 16'h0186);
    cyc(2);
    chk({8'h00, status_vout_out}, 16'h0000, "no warning");
    wr(OVT_CODE_TARGET, 16'h01f4);
    rd(OVT_CODE_TARGET, 16'h0190);
    chk({13'h0, status_word_out[15], status_vout_out[3], alert_out}, 16'h0007, "ceil");
    chk(status_word_out, 16'h8001, "status word");
    clr();
    wr(OVT_CODE_TARGET, 16'h0032);
    rd(OVT_CODE_TARGET, 16'h0064);
    chk({8'h00, status_vout_out}, 16'h0008, "floor warning");
    clr();
    $display("test clamp done");
  endtask
  task automatic t_reload();
    wr(OVT_CODE_TARGET, 16'h0096);
    rail_disabled_in = 1'b1;
    cyc(2);
    rail_disabled_in = 1'b0;
    rd(OVT_CODE_TARGET, 16'h012c);
    wr(OVT_CODE_TARGET, 16'h0096);
    {reset_pin_select_in, address_or_reset_pin_n_in} = 2'b10;
    cyc(4);
    address_or_reset_pin_n_in = 1'b1;
    cyc(4);
    rd(OVT_CODE_TARGET, 16'h012c);
    soft_stop_active_in = 1'b1;
    wr(OVT_CODE_TARGET, 16'h0096);
    rd(OVT_CODE_TARGET, 16'h0096);
    soft_stop_active_in = 1'b0;
    cyc(2);
    rd(OVT_CODE_TARGET, 16'h012c);
    cyc(1);
    ce_in = 1'b0;
    u_ovt_host.xfer(1'b1, OVT_CODE_TARGET, 16'h0096, r, a);
    ce_in = 1'b1;
    chk({15'h0, a}, 16'h0000, "frozen ack");
    rd(OVT_CODE_TARGET, 16'h012c);
    $display("test reload done");
  endtask
  task automatic t_margin();
    wr(OVT_CODE_TARGET, 16'h0096);
    operation_in = 8'h20;
    cyc(200);
    chk(target_out, 16'h012c, "margin high");
    operation_in = 8'h10;
    cyc(260);
    chk(target_out, 16'h004b, "margin low");
    $display("test margin done");
  endtask
  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    {clk_in, reset_n_in, status_clear_in, soft_stop_active_in, rail_disabled_in} = 5'h00;
    {reset_pin_select_in, operation_in, num_errors, check_count, cycles} = '0;
    {ce_in, soft_start_active_in, soft_start_tick_in, transition_tick_in} = 4'he;
    address_or_reset_pin_n_in = 1'b1;
    {vout_max_in, vout_min_in} = {12'h190, 16'h0064};
    {margin_high_in, margin_low_in, scale_loop_in} = {11'h400, 11'h100, 4'h8};
    boot_voltage_setting_in = 13'h012c;
    cyc(2);
    reset_n_in = 1'b1;
    cyc(2);
    t_format();
    t_ramp();
    t_trim();
    t_clamp();
    t_reload();
    t_margin();
    tally_and_finish();
  end
endmodule // tb
